// ==== bench/eswp_host.sv ====
// Host serial controller model that drives the command link
`default_nettype none

module eswp_host (
    // Serial pins
    output logic      sck,
    output logic      cs_n,
    output logic      si,
    input  wire logic so
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle: deselected, clock parked low
    initial begin
        sck  = 1'b0;
        cs_n = 1'b1;
        si   = 1'b0;
    end

    // One frame, 12 ns clock that runs only while selected
    task automatic xfer(input logic [23:0] tx, input int nbits, output logic [15:0] rx);
        rx   = 16'h0000;
        cs_n = 1'b0;
        #7;
        for (int i = nbits - 1; i >= 0; i--) begin
            si = tx[i];
            #6 sck = 1'b1;
            rx = {rx[14:0], so};
            #6 sck = 1'b0;
        end
        #3 cs_n = 1'b1;
        // Released line: show the inverse, not a stale value
        si = ~si;
        #60;
    endtask
endmodule
`default_nettype wire

// ==== bench/eswp_top_test.sv ====
// Self-checking bench for the status and write-protect block
`default_nettype none

module eswp_top_test;
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------
    // Signals and instances
    // ------------------------
    logic            ref_clk;
    logic            resetn;
    logic            clk_en;
    logic            wp_n;
    logic            arr_wr_req;
    logic [9:0]      arr_wr_addr;
    wire logic       sck;
    wire logic       cs_n;
    wire logic       si;
    wire logic       so;
    wire logic       so_oe;
    wire logic       arr_wr_grant;
    wire logic       arr_rd_ok;
    wire logic       hw_protect_o;
    wire logic [7:0] status_o;
    int              err_total;
    int              check_count;
    int              hwpe;
    int              bp;
    int              latch;
    logic [15:0]     rx;
    logic [9:0]      adrs[$] = '{10'h000, 10'h1FF, 10'h200, 10'h2FF, 10'h300, 10'h3FF};

    // Smallest density, short write cycle to keep the run brief
    eswp_top #(.ADDR_W(10), .WRITE_CYCLES(80)) uut (
        .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .sck(sck), .cs_n(cs_n),
        .si(si), .so(so), .so_oe(so_oe), .wp_n(wp_n), .arr_wr_req(arr_wr_req),
        .arr_wr_addr(arr_wr_addr), .arr_wr_grant(arr_wr_grant), .arr_rd_ok(arr_rd_ok),
        .status_o(status_o), .hw_protect_o(hw_protect_o)
    );
    eswp_host host (.sck(sck), .cs_n(cs_n), .si(si), .so(so));

    // 100 MHz system clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ------------------------
    // Checking and model
    // ------------------------
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic summarize();
        if (err_total == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    function automatic logic [7:0] exp_sr(input int busy);
        return {hwpe[0], 3'h0, bp[1:0], latch[0], busy[0]};
    endfunction

    task automatic read_status_cmd(input logic [7:0] e);
        host.xfer({8'h05, 16'h0000}, 24, rx);
        chk("read_status_cmd", rx, {e, e});
    endtask

    task automatic cmd(input logic [7:0] op);
        host.xfer({16'h0000, op}, 8, rx);
        // Look only between clock edges, never in the launching time step
        @(negedge ref_clk);
        if (op == 8'h06) latch = 1;
        if (op == 8'h04) latch = 0;
        chk("latch", status_o, exp_sr(0));
    endtask

    task automatic write_status_cmd(input logic [7:0] d);
        logic ok;
        ok = latch[0] && !(hwpe[0] && !wp_n);
        host.xfer({8'h00, 8'h01, d}, 16, rx);
        @(negedge ref_clk);
        if (ok) begin
            hwpe = d[7];
            bp   = d[3:2];
            chk("busy", status_o, exp_sr(1));
            read_status_cmd(exp_sr(1));
            repeat (100) @(negedge ref_clk);
            latch = 0;
        end
        chk("write_status_cmd", status_o, exp_sr(0));
    endtask

    task automatic arr(input logic [9:0] a);
        logic g;
        g = latch[0] && !(bp == 3 || (bp == 2 && a[9]) || (bp == 1 && a[9:8] == 2'h3));
        @(negedge ref_clk);
        arr_wr_req  = 1'b1;
        arr_wr_addr = a;
        #2 chk("grant", arr_wr_grant, g);
        @(negedge ref_clk);
        if (g) begin
            chk("rd_ok", arr_rd_ok, 1'b0);
            chk("regrant", arr_wr_grant, 1'b0);
        end
        arr_wr_req = 1'b0;
        if (g) begin
            // Frozen enable must stretch the write cycle by the frozen span
            clk_en = 1'b0;
            repeat (20) @(negedge ref_clk);
            clk_en = 1'b1;
            repeat (62) @(negedge ref_clk);
            chk("frozen", status_o, exp_sr(1));
            repeat (30) @(negedge ref_clk);
            latch = 0;
        end
        chk("after", status_o, exp_sr(0));
    endtask

    // ------------------------
    // Main sequence
    // ------------------------
    initial begin
        void'($urandom(16730));
        {hwpe, bp, latch, err_total, check_count} = '0;
        resetn      = 1'b0;
        clk_en      = 1'b1;
        wp_n        = 1'b1;
        arr_wr_req  = 1'b0;
        arr_wr_addr = 10'h000;
        repeat (12) @(negedge ref_clk);
        resetn = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk("reset", status_o, 8'h00);
        chk("so_oe", so_oe, 1'b0);
        cmd(8'h03);
        // A set-latch frame one clock too long must be ignored
        host.xfer({15'h0000, 8'h06, 1'b0}, 9, rx);
        @(negedge ref_clk);
        chk("len", status_o, exp_sr(0));
        arr(10'h000);
        write_status_cmd(8'h8C);
        cmd(8'h06);
        cmd(8'h04);
        for (int b = 0; b < 4; b++) begin
            cmd(8'h06);
            write_status_cmd((8'($urandom) & 8'h73) | 8'(b << 2));
            foreach (adrs[i]) begin
                cmd(8'h06);
                arr(adrs[i]);
            end
            cmd(8'h06);
            arr(10'($urandom));
        end
        cmd(8'h06);
        write_status_cmd(8'h80);
        @(negedge ref_clk);
        wp_n = 1'b0;
        repeat (4) @(negedge ref_clk);
        chk("hw_prot", hw_protect_o, 1'b1);
        cmd(8'h06);
        write_status_cmd(8'h0C);
        arr(10'h3FF);
        wp_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk("hw_prot", hw_protect_o, 1'b0);
        cmd(8'h06);
        write_status_cmd(8'h00);
        summarize();
    end

    // Whole run needs well under 100 us; a hang stops here
    initial begin
        #500us;
        err_total++;
        summarize();
    end
endmodule
`default_nettype wire

// ==== rtl/eswp_defs.svh ====
// Constants of the status register and write-protect block
// Behaviour
// RULE_01: Status readable anytime, even while writing
// RULE_02: Layout: protect enable, blocks, latch, busy
// RULE_03: Busy flag is one during writes
// RULE_04: Latch flag mirrors latch, gates array writes
// RULE_05: Set and clear latch always take effect
// RULE_06: Block bits nonvolatile, changed by status write
// RULE_07: Block code picks none, quarter, half, all
// RULE_08: Protected ranges scale with array size
// RULE_09: Protect enable bit only arms the pin
// RULE_10: Hardware protect needs pin low, enable set
// RULE_11: Hardware protect blocks only status writes
// RULE_12: Latch cleared at power-up
// RULE_13: Idle after power-up, output released
// RULE_14: Latch clears after each completed write
// RULE_15: Host ends write frames at exact count
// RULE_16: Array access ignored during write cycle
// RULE_17: Apply the write permission matrix
// RULE_18: One-byte opcodes, most significant bit first
// RULE_19: Sample on rising, shift on falling edges
// RULE_20: Status write is opcode plus one byte
// RULE_21: Status read repeats while clocks continue
`ifndef ESWP_DEFS_SVH
`define ESWP_DEFS_SVH

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define ESWP_OP_READ_STATUS   8'h05
`define ESWP_OP_WRITE_STATUS  8'h01
`define ESWP_OP_SET_LATCH     8'h06
`define ESWP_OP_CLEAR_LATCH   8'h04

// ----------------------------------------
// Status register field positions
// ----------------------------------------
`define ESWP_SR_HWPE          7
`define ESWP_SR_BPHI          3
`define ESWP_SR_BPLO          2
`define ESWP_SR_LATCH         1
`define ESWP_SR_BUSY          0

// ----------------------------------------
// Reset values and frame lengths
// ----------------------------------------
`define ESWP_NV_RESET         3'h0
`define ESWP_LATCH_RESET      1'b0
`define ESWP_ONE_BYTE         2'h1
`define ESWP_TWO_BYTES        2'h2
`define ESWP_BYTES_MAX        2'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define ESWP_CLK_PERIOD_NS    10
`define ESWP_WRITE_TIME_NS    5000000
`define ESWP_WRITE_CYCLES     ((`ESWP_WRITE_TIME_NS + `ESWP_CLK_PERIOD_NS - 1) / `ESWP_CLK_PERIOD_NS)

`endif

// ==== rtl/eswp_pkg.sv ====
// Types shared by the status and write-protect block
`default_nettype none
`include "eswp_defs.svh"

package eswp_pkg;

    // Decoded command of one frame
    typedef enum logic [2:0] {
        ESWP_CMD_READ_STATUS,
        ESWP_CMD_WRITE_STATUS,
        ESWP_CMD_SET_LATCH,
        ESWP_CMD_CLEAR_LATCH,
        ESWP_CMD_OTHER
    } eswp_cmd_e;

    // Write cycle timer states
    typedef enum logic {
        ESWP_TMR_IDLE,
        ESWP_TMR_RUN
    } eswp_tmr_e;

    typedef logic [7:0] eswp_byte_t;

    // Opcode decode, shared by link and register logic
    function automatic eswp_cmd_e eswp_decode(input eswp_byte_t op);
        if (op == `ESWP_OP_READ_STATUS) begin
            return ESWP_CMD_READ_STATUS;
        end else if (op == `ESWP_OP_WRITE_STATUS) begin
            return ESWP_CMD_WRITE_STATUS;
        end else if (op == `ESWP_OP_SET_LATCH) begin
            return ESWP_CMD_SET_LATCH;
        end else if (op == `ESWP_OP_CLEAR_LATCH) begin
            return ESWP_CMD_CLEAR_LATCH;
        end else begin
            return ESWP_CMD_OTHER;
        end
    endfunction

endpackage
`default_nettype wire

// ==== rtl/eswp_sync.sv ====
// Two-stage synchroniser for independent level signals
`default_nettype none

module eswp_sync #(
    parameter int unsigned WIDTH     = 1,
    parameter logic [31:0] RESET_VAL = 32'h0000_0000
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             resetn,
    // Levels in and out
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_reg <= RESET_VAL[WIDTH-1:0];
            q        <= RESET_VAL[WIDTH-1:0];
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end

endmodule
`default_nettype wire

// ==== rtl/eswp_top.sv ====
// Status register, serial command link and write-protect decisions
`default_nettype none
`include "eswp_defs.svh"

module eswp_top #(
    parameter int unsigned ADDR_W       = 15,
    parameter int unsigned WRITE_CYCLES = `ESWP_WRITE_CYCLES
) (
    // Clock, reset, enable
    input  wire logic              ref_clk,
    input  wire logic              resetn,
    input  wire logic              clk_en,
    // Serial link pins
    input  wire logic              sck,
    input  wire logic              cs_n,
    input  wire logic              si,
    output logic                   so,
    output logic                   so_oe,
    input  wire logic              wp_n,
    // Array write permission
    input  wire logic              arr_wr_req,
    input  wire logic [ADDR_W-1:0] arr_wr_addr,
    output logic                   arr_wr_grant,
    output logic                   arr_rd_ok,
    // Status view
    output logic [7:0]             status_o,
    output logic                   hw_protect_o
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic                  frame_clr;
    logic                  frame_seen;
    logic                  frame_tog;
    logic [2:0]            bit_idx;
    logic [1:0]            byte_cnt;
    eswp_pkg::eswp_byte_t  shift_in;
    eswp_pkg::eswp_byte_t  opcode_lnk;
    eswp_pkg::eswp_byte_t  data_lnk;
    eswp_pkg::eswp_byte_t  out_sh;
    logic                  so_oe_reg;
    logic [4:0]            stat_src;
    logic [4:0]            stat_lnk;
    eswp_pkg::eswp_byte_t  stat_byte_lnk;
    logic                  op_is_read;

    logic                  cs_s;
    logic                  wp_s;
    logic                  tog_s;
    logic                  cs_d;
    logic                  tog_seen;
    logic                  cs_rise;
    logic                  frame_end;
    eswp_pkg::eswp_cmd_e   cmd;
    logic                  one_byte;
    logic                  two_bytes;
    logic                  set_latch_evt;
    logic                  clr_latch_evt;
    logic                  write_status_cmd_acc;
    logic                  hw_prot;
    logic                  timer_start;
    logic                  busy;
    logic                  timer_done;
    logic                  latch_reg;
    logic                  hwpe_reg;
    logic [1:0]            bp_reg;

    // Block-protect code to a verdict for one address
    function automatic logic addr_protected(input logic [1:0]        bp,
                                            input logic [ADDR_W-1:0] addr);
        logic result;
        result = 1'b0;
        case (bp)
            2'b00:   result = 1'b0;                             // see RULE_07
            2'b01:   result = &addr[ADDR_W-1:ADDR_W-2];         // see RULE_08
            2'b10:   result = addr[ADDR_W-1];                   // see RULE_08
            default: result = 1'b1;                             // see RULE_07
        endcase
        return result;
    endfunction

    // ----------------------------------------
    // Link domain, clocked by sck
    // ----------------------------------------

    // Deselect or reset ends the frame at once, sck may stop afterwards
    assign frame_clr = cs_n | ~resetn;

    // Marks that the frame has seen its first rising edge
    always_ff @(posedge sck or posedge frame_clr) begin
        if (frame_clr) begin
            frame_seen <= 1'b0;
        end else begin
            frame_seen <= 1'b1;
        end
    end

    // Toggle per frame, so a select with no clocks replays nothing
    always_ff @(posedge sck or negedge resetn) begin
        if (!resetn) begin
            frame_tog <= 1'b0;
        end else if (!frame_seen) begin
            frame_tog <= ~frame_tog;
        end
    end

    // Bit and byte counting; counts stay frozen after deselect
    always_ff @(posedge sck or negedge resetn) begin
        if (!resetn) begin
            bit_idx  <= 3'h0;
            byte_cnt <= 2'h0;
        end else if (!frame_seen) begin
            bit_idx  <= 3'h1;
            byte_cnt <= 2'h0;
        end else begin
            bit_idx <= bit_idx + 3'h1;
            if (bit_idx == 3'h7 && byte_cnt != `ESWP_BYTES_MAX) begin
                byte_cnt <= byte_cnt + 2'h1;
            end
        end
    end

    // Input shifting on rising edges, most significant bit first
    always_ff @(posedge sck or negedge resetn) begin
        if (!resetn) begin
            shift_in   <= 8'h00;
            opcode_lnk <= 8'h00;
            data_lnk   <= 8'h00;
        end else begin
            shift_in <= {shift_in[6:0], si};                    // see RULE_19
            if (frame_seen && bit_idx == 3'h7 && byte_cnt == 2'h0) begin
                opcode_lnk <= {shift_in[6:0], si};              // see RULE_18
            end
            if (frame_seen && bit_idx == 3'h7 && byte_cnt == `ESWP_ONE_BYTE) begin
                data_lnk <= {shift_in[6:0], si};                // see RULE_20
            end
        end
    end

    // Status bits into the link domain; only busy and latch move inside a frame
    assign stat_src = {hwpe_reg, bp_reg, latch_reg, busy};

    eswp_sync #(
        .WIDTH     (5),
        .RESET_VAL (32'h0000_0000)
    ) u_stat_sync (
        .clk    (sck),
        .resetn (resetn),
        .d      (stat_src),
        .q      (stat_lnk)
    );

    assign stat_byte_lnk = {stat_lnk[4], 3'b000, stat_lnk[3:1], stat_lnk[0]}; // see RULE_02
    assign op_is_read    = (eswp_pkg::eswp_decode(opcode_lnk) == eswp_pkg::ESWP_CMD_READ_STATUS);

    // Output shifting on falling edges, reloaded every byte
    always_ff @(negedge sck or posedge frame_clr) begin
        if (frame_clr) begin
            out_sh    <= 8'h00;                                 // see RULE_13
            so_oe_reg <= 1'b0;
        end else if (frame_seen && bit_idx == 3'h0 && byte_cnt != 2'h0 && op_is_read) begin
            out_sh    <= stat_byte_lnk;                         // see RULE_21
            so_oe_reg <= 1'b1;                                  // see RULE_01
        end else begin
            out_sh <= {out_sh[6:0], 1'b0};                      // see RULE_19
        end
    end

    assign so    = out_sh[7];
    assign so_oe = so_oe_reg;

    // ----------------------------------------
    // Register domain, clocked by ref_clk
    // ----------------------------------------

    // Pin and frame-toggle synchronisers; select idles high
    eswp_sync #(
        .WIDTH     (3),
        .RESET_VAL (32'h0000_0006)
    ) u_pin_sync (
        .clk    (ref_clk),
        .resetn (resetn),
        .d      ({cs_n, wp_n, frame_tog}),
        .q      ({cs_s, wp_s, tog_s})
    );

    // Deselect edge and frame bookkeeping
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cs_d     <= 1'b1;
            tog_seen <= 1'b0;
        end else if (clk_en) begin
            cs_d <= cs_s;
            if (cs_rise) begin
                tog_seen <= tog_s;
            end
        end
    end

    // Link fields are stable here: sck is quiet once deselected
    assign cs_rise   = cs_s & ~cs_d & clk_en;
    assign frame_end = cs_rise & (tog_s != tog_seen);
    assign cmd       = eswp_pkg::eswp_decode(opcode_lnk);
    assign one_byte  = (byte_cnt == `ESWP_ONE_BYTE) && (bit_idx == 3'h0);  // see RULE_15
    assign two_bytes = (byte_cnt == `ESWP_TWO_BYTES) && (bit_idx == 3'h0); // see RULE_15

    // Latch commands act whatever the protection state
    assign set_latch_evt = frame_end && one_byte && cmd == eswp_pkg::ESWP_CMD_SET_LATCH; // see RULE_05
    assign clr_latch_evt = frame_end && one_byte && cmd == eswp_pkg::ESWP_CMD_CLEAR_LATCH; // see RULE_05

    // Pin only counts while the enable bit is set
    assign hw_prot = ~wp_s & hwpe_reg;                          // see RULE_10

    // Status write needs latch, no hardware protect, no write running
    assign write_status_cmd_acc = frame_end && two_bytes && cmd == eswp_pkg::ESWP_CMD_WRITE_STATUS
                   && latch_reg && !hw_prot && !busy;           // see RULE_17

    // Array writes ignore the pin, obey latch and block bits
    assign arr_wr_grant = arr_wr_req && clk_en && latch_reg && !busy
                       && !addr_protected(bp_reg, arr_wr_addr); // see RULE_11
    assign arr_rd_ok    = ~busy;                                // see RULE_16

    assign timer_start = write_status_cmd_acc | arr_wr_grant;

    eswp_wr_timer #(
        .CYCLES (WRITE_CYCLES)
    ) u_timer (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .clk_en  (clk_en),
        .start   (timer_start),
        .busy    (busy),                                        // see RULE_03
        .done    (timer_done)
    );

    // Write latch: set wins over any clear in the same cycle
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            latch_reg <= `ESWP_LATCH_RESET;                     // see RULE_12
        end else if (clk_en) begin
            if (set_latch_evt) begin
                latch_reg <= 1'b1;                              // see RULE_05
            end else if (clr_latch_evt || timer_done) begin
                latch_reg <= 1'b0;                              // see RULE_14
            end
        end
    end

    // Nonvolatile bits, held as flops; only an accepted status write moves them
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            {hwpe_reg, bp_reg} <= `ESWP_NV_RESET;
        end else if (clk_en && write_status_cmd_acc) begin
            hwpe_reg <= data_lnk[`ESWP_SR_HWPE];                // see RULE_09
            bp_reg   <= {data_lnk[`ESWP_SR_BPHI], data_lnk[`ESWP_SR_BPLO]}; // see RULE_06
        end
    end

    // Status as seen by the host, unused bits zero
    always_comb begin
        status_o                 = 8'h00;
        status_o[`ESWP_SR_HWPE]  = hwpe_reg;
        status_o[`ESWP_SR_BPHI]  = bp_reg[1];
        status_o[`ESWP_SR_BPLO]  = bp_reg[0];
        status_o[`ESWP_SR_LATCH] = latch_reg;                   // see RULE_04
        status_o[`ESWP_SR_BUSY]  = busy;                        // see RULE_03
    end

    assign hw_protect_o = hw_prot;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb_ref @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    property p_unused_zero;
        status_o[6:4] == 3'b000;
    endproperty
    a_unused_zero: assert property (p_unused_zero) // see RULE_02
        else $error("unused status bits not zero");

    property p_grant_starts_busy;
        arr_wr_grant |=> status_o[`ESWP_SR_BUSY] && !arr_rd_ok;
    endproperty
    a_grant_starts_busy: assert property (p_grant_starts_busy) // see RULE_03
        else $error("busy not raised after array write grant");

    property p_no_latch_no_write;
        !status_o[`ESWP_SR_LATCH] |-> !arr_wr_grant;
    endproperty
    a_no_latch_no_write: assert property (p_no_latch_no_write) // see RULE_04
        else $error("array write granted with latch clear");

    property p_set_latch;
        set_latch_evt |=> status_o[`ESWP_SR_LATCH];
    endproperty
    a_set_latch: assert property (p_set_latch) // see RULE_05
        else $error("set latch command not applied");

    property p_bp_stable;
        clk_en && !write_status_cmd_acc |=> $stable(status_o[3:2]) && $stable(status_o[7]);
    endproperty
    a_bp_stable: assert property (p_bp_stable) // see RULE_06
        else $error("nonvolatile bits changed without status write");

    property p_full_protect;
        arr_wr_req && status_o[3:2] == 2'b11 |-> !arr_wr_grant;
    endproperty
    a_full_protect: assert property (p_full_protect) // see RULE_07
        else $error("write granted with whole array protected");

    property p_hw_blocks_status;
        hw_protect_o && frame_end |=> $stable(status_o[7:2]) ##1 $stable(status_o[7:2]);
    endproperty
    a_hw_blocks_status: assert property (p_hw_blocks_status) // see RULE_10
        else $error("status written under hardware protection");

    property p_latch_clears_after_write;
        $fell(busy) && !$past(set_latch_evt) |-> !latch_reg;
    endproperty
    a_latch_clears_after_write: assert property (p_latch_clears_after_write) // see RULE_14
        else $error("latch still set after write cycle");

    property p_busy_blocks_array;
        busy |-> !arr_rd_ok && !arr_wr_grant;
    endproperty
    a_busy_blocks_array: assert property (p_busy_blocks_array) // see RULE_16
        else $error("array access allowed during write cycle");

    property p_status_write_busy;
        write_status_cmd_acc |=> busy [*2];
    endproperty
    a_status_write_busy: assert property (p_status_write_busy) // see RULE_20
        else $error("status write did not start write cycle");

    property p_status_write_needs_latch;
        write_status_cmd_acc |-> status_o[`ESWP_SR_LATCH] && !hw_protect_o;
    endproperty
    a_status_write_needs_latch: assert property (p_status_write_needs_latch) // see RULE_17
        else $error("status write accepted without permission");

    // Main scenarios
    c_status_write: cover property (write_status_cmd_acc ##1 busy);
    c_array_write:  cover property (arr_wr_grant ##1 busy);
    c_hw_blocked:   cover property (frame_end && hw_prot && latch_reg);
    c_set_latch:    cover property (set_latch_evt ##1 latch_reg);

endmodule
`default_nettype wire

// ==== rtl/eswp_wr_timer.sv ====
// Internal write cycle timer that drives the busy flag
`default_nettype none

module eswp_wr_timer #(
    parameter int unsigned CYCLES = 16
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic resetn,
    input  wire logic clk_en,
    // Control
    input  wire logic start,
    output logic      busy,
    output logic      done
);

    localparam int unsigned CW = $clog2(CYCLES + 1);

    eswp_pkg::eswp_tmr_e state_reg;
    logic [CW-1:0]       cnt_reg;

    // Count down the write time; a start while running is ignored
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= eswp_pkg::ESWP_TMR_IDLE;
            cnt_reg   <= '0;
        end else if (clk_en) begin
            case (state_reg)
                eswp_pkg::ESWP_TMR_IDLE: begin
                    if (start) begin
                        state_reg <= eswp_pkg::ESWP_TMR_RUN;
                        cnt_reg   <= CW'(CYCLES - 1);
                    end
                end
                eswp_pkg::ESWP_TMR_RUN: begin
                    if (cnt_reg == '0) begin
                        state_reg <= eswp_pkg::ESWP_TMR_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - CW'(1);
                    end
                end
                default: begin
                    state_reg <= eswp_pkg::ESWP_TMR_IDLE;
                end
            endcase
        end
    end

    // Busy straight from state, done on the last cycle
    assign busy = (state_reg == eswp_pkg::ESWP_TMR_RUN);
    assign done = busy && (cnt_reg == '0) && clk_en;

endmodule
`default_nettype wire
